// ---- rtl/crma_consts.vh ----
// Purpose: constants for the configuration register message access block
// Assumes: token stream is one byte or control token per beat
// Notes: definitions only
`ifndef CRMA_CONSTS_VH
`define CRMA_CONSTS_VH
`define CRMA_CT_WRITE 8'hc0
`define CRMA_CT_READ 8'hc1
`define CRMA_CT_END 8'h01
`define CRMA_CT_ACK 8'h03
`define CRMA_CT_NACK 8'h04
`define CRMA_NO_REPLY 8'hff
`define CRMA_PS_TYPE 8'h0c
`define CRMA_PS_SHIFT 8
`define CRMA_REG_AW 4
`define CRMA_REG_NUM 16
`endif

// ---- rtl/crma_regmem.v ----
// Purpose: small register storage with registered read data
// Assumes: one access per cycle
// Notes: contents reset to zero
`timescale 1ns/1ns
`default_nettype none
`include "crma_consts.vh"
module crma_regmem (
    // clock and reset
    input wire i_clk,
    input wire i_rst_b,
    // access
    input wire i_we,
    input wire [`CRMA_REG_AW-1:0] i_addr,
    input wire [31:0] i_wdata,
    output reg [31:0] o_rdata
);
    reg [31:0] mem_q [0:`CRMA_REG_NUM-1];
    integer k;
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (k = 0; k < `CRMA_REG_NUM; k = k + 1) begin
                mem_q[k] <= 32'h0;
            end
            o_rdata <= 32'h0;
        end else begin
            if (i_we) begin
                mem_q[i_addr] <= i_wdata;
            end
            o_rdata <= mem_q[i_addr];
        end
    end
endmodule // crma_regmem
`default_nettype wire

// ---- rtl/crma_top.v ----
// Purpose: serve register read and write request messages on a token stream
// Assumes: i_rx_ctl marks a control token; output beats held until i_tx_ready
// Notes: registers 0..15 exist; a status word port gives processor access
`timescale 1ns/1ns
`default_nettype none
`include "crma_consts.vh"
module crma_top (
    // clock and reset
    input wire i_clk,
    input wire i_rst_b,
    // request stream in
    input wire i_rx_valid,
    input wire i_rx_ctl,
    input wire [7:0] i_rx_data,
    output reg o_rx_ready,
    // reply stream out
    output reg o_tx_valid,
    output reg o_tx_ctl,
    output reg [7:0] o_tx_data,
    output reg [23:0] o_tx_dest,
    input wire i_tx_ready,
    // processor status access
    input wire i_ps_req,
    input wire i_ps_we,
    input wire [31:0] i_ps_id,
    input wire [31:0] i_ps_wdata,
    output reg o_ps_ack,
    output reg o_ps_err,
    output reg [31:0] o_ps_rdata
);
    localparam S_CMD = 3'd0, S_DEST = 3'd1, S_REG = 3'd2, S_DATA = 3'd3;
    localparam S_END = 3'd4, S_DRAIN = 3'd5, S_MEM = 3'd6, S_TX = 3'd7;

    reg [2:0] st_q;
    reg wr_q, bad_q, skip_q;
    reg [1:0] cnt_q;
    reg [23:0] dest_q;
    reg [15:0] reg_q;
    reg [31:0] data_q;
    reg [2:0] tx_q;
    reg mem_we, ps_pend_q, ps_we_q;
    reg [`CRMA_REG_AW-1:0] mem_addr;
    wire [31:0] mem_rdata;

    // register number is valid only inside the implemented range
    function reg_ok;
        input [15:0] n;
        reg_ok = (n < `CRMA_REG_NUM);
    endfunction

    // status id check: low byte is the type, register number above
    wire [23:0] ps_num = i_ps_id[31:`CRMA_PS_SHIFT];
    wire ps_ok = (i_ps_id[7:0] == `CRMA_PS_TYPE) && (ps_num < `CRMA_REG_NUM);
    // a message owns the memory port on its end edge, so the status port waits then
    wire msg_busy = (st_q == S_MEM) ||
        (st_q == S_END && i_rx_valid && o_rx_ready && i_rx_ctl && i_rx_data == `CRMA_CT_END);
    wire ps_go = ps_pend_q && !msg_busy;

    always @* begin
        mem_we = 1'b0;
        mem_addr = reg_q[`CRMA_REG_AW-1:0];
        if (st_q == S_END && !bad_q && wr_q && i_rx_valid && o_rx_ready && i_rx_ctl &&
            i_rx_data == `CRMA_CT_END && reg_ok(reg_q)) begin
            mem_we = 1'b1;
        end else if (ps_go) begin
            mem_addr = ps_num[`CRMA_REG_AW-1:0];
            mem_we = ps_we_q && ps_ok;
        end
    end

    crma_regmem u_mem (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_we(mem_we),
        .i_addr(mem_addr),
        .i_wdata(ps_go ? i_ps_wdata : data_q),
        .o_rdata(mem_rdata)
    );

    // processor status port; one cycle ack after request is granted
    reg ps_rd_q, ps_ok_q;
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ps_pend_q <= 1'b0;
            ps_we_q <= 1'b0;
            ps_rd_q <= 1'b0;
            ps_ok_q <= 1'b0;
            o_ps_ack <= 1'b0;
            o_ps_err <= 1'b0;
            o_ps_rdata <= 32'h0;
        end else begin
            o_ps_ack <= 1'b0;
            ps_rd_q <= 1'b0;
            if (i_ps_req && !ps_pend_q && !ps_rd_q) begin
                ps_pend_q <= 1'b1;
                ps_we_q <= i_ps_we;
            end else if (ps_go) begin
                ps_pend_q <= 1'b0;
                ps_rd_q <= 1'b1;
                ps_ok_q <= ps_ok;
            end
            if (ps_rd_q) begin
                o_ps_ack <= 1'b1;
                o_ps_err <= !ps_ok_q;
                o_ps_rdata <= ps_ok_q ? mem_rdata : 32'h0;
            end
        end
    end

    wire take = i_rx_valid && o_rx_ready;
    wire is_end = i_rx_ctl && i_rx_data == `CRMA_CT_END;

    // reply beat sequence: tx_q counts ack, four data bytes on a good read only, end
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q <= S_CMD;
            wr_q <= 1'b0;
            bad_q <= 1'b0;
            skip_q <= 1'b0;
            cnt_q <= 2'd0;
            dest_q <= 24'h0;
            reg_q <= 16'h0;
            data_q <= 32'h0;
            tx_q <= 3'd0;
            o_rx_ready <= 1'b0;
            o_tx_valid <= 1'b0;
            o_tx_ctl <= 1'b0;
            o_tx_data <= 8'h0;
            o_tx_dest <= 24'h0;
        end else begin
            case (st_q)
                S_CMD: begin
                    o_rx_ready <= 1'b1;
                    if (take) begin
                        cnt_q <= 2'd0;
                        bad_q <= 1'b0;
                        skip_q <= 1'b0;
                        if (i_rx_ctl && i_rx_data == `CRMA_CT_WRITE) begin
                            wr_q <= 1'b1;
                            st_q <= S_DEST;
                        end else if (i_rx_ctl && i_rx_data == `CRMA_CT_READ) begin
                            wr_q <= 1'b0;
                            st_q <= S_DEST;
                        end else if (!is_end) begin
                            skip_q <= 1'b1;
                            st_q <= S_DRAIN; // garbage opener: skip to end token, no reply possible
                        end
                    end
                end
                S_DEST: if (take) begin
                    if (i_rx_ctl) bad_q <= 1'b1;
                    dest_q <= {dest_q[15:0], i_rx_data};
                    cnt_q <= cnt_q + 2'd1;
                    if (cnt_q == 2'd2) begin
                        cnt_q <= 2'd0;
                        st_q <= S_REG;
                    end
                end
                S_REG: if (take) begin
                    if (i_rx_ctl) bad_q <= 1'b1;
                    reg_q <= {reg_q[7:0], i_rx_data};
                    cnt_q <= cnt_q + 2'd1;
                    if (cnt_q == 2'd1) begin
                        cnt_q <= 2'd0;
                        st_q <= wr_q ? S_DATA : S_END;
                    end
                end
                S_DATA: if (take) begin
                    if (i_rx_ctl) bad_q <= 1'b1;
                    data_q <= {data_q[23:0], i_rx_data};
                    cnt_q <= cnt_q + 2'd1;
                    if (cnt_q == 2'd3) st_q <= S_END;
                end
                S_END: if (take) begin
                    if (!is_end) begin
                        bad_q <= 1'b1;
                        st_q <= S_DRAIN;
                    end else begin
                        bad_q <= bad_q || !reg_ok(reg_q);
                        o_rx_ready <= 1'b0;
                        st_q <= S_MEM;
                    end
                end
                S_DRAIN: if (take && is_end) begin
                    o_rx_ready <= 1'b0;
                    st_q <= S_MEM;
                end
                S_MEM: begin
                    // read data is registered, so wait here one cycle
                    tx_q <= 3'd0;
                    data_q <= (!wr_q && !bad_q) ? mem_rdata : data_q;
                    if (skip_q || (wr_q && dest_q[7:0] == `CRMA_NO_REPLY)) begin
                        st_q <= S_CMD;
                    end else begin
                        o_tx_dest <= dest_q;
                        o_tx_valid <= 1'b1;
                        o_tx_ctl <= 1'b1;
                        o_tx_data <= bad_q ? `CRMA_CT_NACK : `CRMA_CT_ACK;
                        st_q <= S_TX;
                    end
                end
                default: if (i_tx_ready) begin
                    tx_q <= tx_q + 3'd1;
                    if (o_tx_ctl && o_tx_data == `CRMA_CT_END && tx_q != 3'd0) begin
                        o_tx_valid <= 1'b0;
                        st_q <= S_CMD;
                    end else if (tx_q == 3'd0 && (wr_q || bad_q) || tx_q == 3'd4) begin
                        o_tx_ctl <= 1'b1;
                        o_tx_data <= `CRMA_CT_END;
                        tx_q <= 3'd5;
                    end else begin
                        o_tx_ctl <= 1'b0;
                        o_tx_data <= data_q[31:24];
                        data_q <= {data_q[23:0], 8'h0};
                    end
                end
            endcase
        end
    end
endmodule // crma_top
`default_nettype wire

// ---- sim/crma_top_properties.sv ----
// Purpose: checks on the reply stream and status port
// Assumes: one clock, async low reset
// Notes: bound to crma_top
`timescale 1ns/1ns
`default_nettype none
module crma_top_properties (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_rx_valid,
    input wire logic i_rx_ctl,
    input wire logic [7:0] i_rx_data,
    input wire logic o_rx_ready,
    input wire logic o_tx_valid,
    input wire logic o_tx_ctl,
    input wire logic [7:0] o_tx_data,
    input wire logic i_tx_ready,
    input wire logic i_ps_req,
    input wire logic o_ps_ack
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    wire end_in = i_rx_valid && o_rx_ready && i_rx_ctl && i_rx_data == 8'h01;
    wire end_out = o_tx_valid && i_tx_ready && o_tx_ctl && o_tx_data == 8'h01;
    beat_hold_a: assert property (
        o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data) && $stable(o_tx_ctl)) else $error("beat moved");
    reply_open_a: assert property (
        $rose(o_tx_valid) |-> o_tx_ctl && (o_tx_data == 8'h03 || o_tx_data == 8'h04)) else $error("bad opener");
    nack_end_a: assert property (
        o_tx_valid && i_tx_ready && o_tx_ctl && o_tx_data == 8'h04 |-> ##[1:3] end_out) else $error("no end");
    ready_low_a: assert property (
        o_tx_valid |-> !o_rx_ready) else $error("ready in reply");
    reply_cause_a: assert property (
        $rose(o_tx_valid) |-> $past(end_in, 1) || $past(end_in, 2) || $past(end_in, 3)) else $error("late reply");
    ready_back_a: assert property (
        end_out |-> ##[1:3] o_rx_ready) else $error("ready stuck");
    ps_ack_a: assert property (
        i_ps_req |-> ##[1:6] o_ps_ack) else $error("no ack");
    ack_pulse_a: assert property (
        o_ps_ack |=> !o_ps_ack) else $error("long ack");
    cover property ($rose(o_tx_valid) && o_tx_data == 8'h03);
    cover property ($rose(o_tx_valid) && o_tx_data == 8'h04);
    cover property (o_ps_ack);
endmodule // crma_top_properties
bind crma_top crma_top_properties crma_top_properties_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_rx_valid(i_rx_valid), .i_rx_ctl(i_rx_ctl), .i_rx_data(i_rx_data), .o_rx_ready(o_rx_ready),
    .o_tx_valid(o_tx_valid), .o_tx_ctl(o_tx_ctl), .o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready),
    .i_ps_req(i_ps_req), .o_ps_ack(o_ps_ack));
`default_nettype wire

// ---- sim/crma_sink.sv ----
// Purpose: requester channel end taking reply beats
// Assumes: slow mode toggles ready every cycle
// Notes: beats kept as {dest, ctl, data}
`timescale 1ns/1ns
`default_nettype none
module crma_sink (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_slow,
    input wire logic i_valid,
    input wire logic i_ctl,
    input wire logic [7:0] i_data,
    input wire logic [23:0] i_dest,
    output logic o_ready
);
    logic [32:0] got[$];
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) o_ready <= 1'b0;
        else o_ready <= i_slow ? !o_ready : 1'b1;
    end
    always @(posedge i_clk) begin
        if (i_rst_b && i_valid && o_ready) got.push_back({i_dest, i_ctl, i_data});
    end
endmodule // crma_sink
`default_nettype wire

// ---- sim/crma_top_tb_top.sv ----
// Purpose: scenario bench for crma_top
// Assumes: bench drives inputs after rising edges
// Notes: replies gathered by crma_sink
`timescale 1ns/1ns
`default_nettype none
module crma_top_tb_top;
    logic i_clk = 0, i_rst_b = 0, i_rx_valid = 0, i_rx_ctl = 0, i_ps_req = 0, i_ps_we = 0, slow = 0;
    logic [7:0] i_rx_data = 8'h00;
    logic [31:0] i_ps_id = 32'h0, i_ps_wdata = 32'h0;
    wire o_rx_ready, o_tx_valid, o_tx_ctl, i_tx_ready, o_ps_ack, o_ps_err;
    wire [7:0] o_tx_data;
    wire [23:0] o_tx_dest;
    wire [31:0] o_ps_rdata;
    int n_mismatch = 0, checked = 0;
    logic [8:0] ex[0:5];
    always #2 i_clk = ~i_clk;
    crma_top crma_top_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_rx_valid(i_rx_valid), .i_rx_ctl(i_rx_ctl),
        .i_rx_data(i_rx_data), .o_rx_ready(o_rx_ready), .o_tx_valid(o_tx_valid), .o_tx_ctl(o_tx_ctl),
        .o_tx_data(o_tx_data), .o_tx_dest(o_tx_dest), .i_tx_ready(i_tx_ready), .i_ps_req(i_ps_req),
        .i_ps_we(i_ps_we), .i_ps_id(i_ps_id), .i_ps_wdata(i_ps_wdata), .o_ps_ack(o_ps_ack),
        .o_ps_err(o_ps_err), .o_ps_rdata(o_ps_rdata));
    crma_sink crma_sink_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_slow(slow), .i_valid(o_tx_valid),
        .i_ctl(o_tx_ctl), .i_data(o_tx_data), .i_dest(o_tx_dest), .o_ready(i_tx_ready));
    task end_of_test;
        if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [35:0] s, input logic [35:0] e, input string w);
        checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", w, e, s);
        end
    endtask
    task beat(input logic c, input logic [7:0] d);
        i_rx_valid <= 1'b1;
        i_rx_ctl <= c;
        i_rx_data <= d;
        @(posedge i_clk);
        while (o_rx_ready !== 1'b1) @(posedge i_clk);
    endtask
    task send(input logic [7:0] op, input logic [23:0] dst, input logic [15:0] rn, input logic [31:0] wd);
        beat(1'b1, op);
        for (int i = 2; i >= 0; i--) beat(1'b0, dst[i*8 +: 8]);
        for (int i = 1; i >= 0; i--) beat(1'b0, rn[i*8 +: 8]);
        if (op == 8'hc0) for (int i = 3; i >= 0; i--) beat(1'b0, wd[i*8 +: 8]);
        beat(1'b1, 8'h01);
        i_rx_valid <= 1'b0;
    endtask
    task rsp(input int n, input logic [23:0] dst);
        for (int k = 0; k < 200 && crma_sink_inst.got.size() < n; k++) @(posedge i_clk);
        for (int i = 0; i < n; i++) chk(crma_sink_inst.got.size() ? crma_sink_inst.got.pop_front() : 33'h0,
            {dst, ex[i]}, "reply");
    endtask
    task ps(input logic we, input logic [7:0] rn, input logic [7:0] ty, input logic [31:0] wd,
        output logic [32:0] r);
        i_ps_req <= 1'b1;
        i_ps_we <= we;
        i_ps_id <= {16'h0, rn, ty};
        i_ps_wdata <= wd;
        @(posedge i_clk);
        i_ps_req <= 1'b0;
        for (int k = 0; k < 50 && o_ps_ack !== 1'b1; k++) @(posedge i_clk);
        chk(o_ps_ack, 1'b1, "ps_ack");
        r = {o_ps_err, o_ps_rdata};
    endtask
    task t_wr_rd;
        slow <= 1'b1;
        send(8'hc0, 24'h123456, 16'h0005, 32'ha1b2c3d4);
        ex = '{9'h103, 9'h101, 9'h0, 9'h0, 9'h0, 9'h0};
        rsp(2, 24'h123456);
        send(8'hc1, 24'h654321, 16'h0005, 32'h0);
        ex = '{9'h103, 9'h0a1, 9'h0b2, 9'h0c3, 9'h0d4, 9'h101};
        rsp(6, 24'h654321);
    endtask
    task t_quiet;
        slow <= 1'b0;
        send(8'hc0, 24'h4321ff, 16'h0006, 32'h0f1e2d3c);
        repeat (20) @(posedge i_clk);
        chk(crma_sink_inst.got.size(), 0, "quiet");
        send(8'hc1, 24'h000102, 16'h0006, 32'h0);
        ex = '{9'h103, 9'h00f, 9'h01e, 9'h02d, 9'h03c, 9'h101};
        rsp(6, 24'h000102);
    endtask
    task t_bad;
        send(8'hc1, 24'h0a0b0c, 16'h0010, 32'h0);
        ex[0] = 9'h104;
        ex[1] = 9'h101;
        rsp(2, 24'h0a0b0c);
        send(8'hc0, 24'h0a0b0c, 16'h0100, 32'h1);
        rsp(2, 24'h0a0b0c);
        beat(1'b1, 8'h05);
        beat(1'b0, 8'h55);
        beat(1'b1, 8'h01);
        i_rx_valid <= 1'b0;
        repeat (20) @(posedge i_clk);
        chk(crma_sink_inst.got.size(), 0, "junk");
        beat(1'b1, 8'hc1);
        beat(1'b0, 8'h0a);
        beat(1'b0, 8'h0b);
        beat(1'b0, 8'h0c);
        beat(1'b1, 8'h00);
        beat(1'b0, 8'h01);
        beat(1'b1, 8'h01);
        i_rx_valid <= 1'b0;
        rsp(2, 24'h0a0b0c);
    endtask
    task t_ps;
        logic [32:0] r;
        ps(1'b1, 8'h03, 8'h0c, 32'h55aa00ff, r);
        chk(r[32], 1'b0, "ps_wr");
        ps(1'b0, 8'h03, 8'h0c, 32'h0, r);
        chk(r, {1'b0, 32'h55aa00ff}, "ps_rd");
        ps(1'b0, 8'h05, 8'h0c, 32'h0, r);
        chk(r, {1'b0, 32'ha1b2c3d4}, "ps_shared");
        ps(1'b0, 8'h03, 8'h0d, 32'h0, r);
        chk(r[32], 1'b1, "ps_type");
    endtask
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (2) @(posedge i_clk);
        t_wr_rd();
        t_quiet();
        t_bad();
        t_ps();
        end_of_test();
    end
    initial begin
        #20000;
        n_mismatch++;
        end_of_test();
    end
endmodule // crma_top_tb_top
`default_nettype wire
